// ==== rtl/ssc_pkg.sv ====
// constants for the superframe sync and clock output block
//
// Notes on behaviour
// - sync pulse goes high eight bauds before the frame one/two sync word.
// - sync pulse only when clock enable and sync enable bits are both one.
// - sync pulse edges change with the transmit baud clock rising edge.
// - alignment pin is an input in line-card mode, an output in terminal mode.
// - alignment function works only with the alignment enable bit set.
// - in line-card mode, second init bit 5 makes alignment pin an output.
// - host mode, bus mode and first init bit 3 take alignment from frame sync.
// - alignment pulse marks the bus frame that starts the line superframe.
// - alignment pin stays undriven after reset until explicitly configured.
// - line-card mode takes an 8 kHz reference; lock is monitored by period.
// - terminal host mode plus second init bit 4 drives data clock on ref pin.
// - reference output rate set by bus format bit 2 and timeslot bit 4.
// - locked output carries the clock in bus-controlled mode only, and not while baud clock output runs.
// - terminal mode data clock at 512 kHz, 2.048 MHz or 2.56 MHz.
// - transmit baud clock runs at 80 kHz, one period per baud.
package ssc_pkg;
    // ************************************************************
    // register map, 8-bit registers at word indices
    // ************************************************************
    localparam logic [2:0] REG_TEST_CTRL = 3'h0;
    localparam logic [2:0] REG_EXT_CTRL = 3'h1;
    localparam logic [2:0] REG_FIRST_INIT = 3'h2;
    localparam logic [2:0] REG_SECOND_INIT = 3'h3;
    localparam logic [2:0] REG_TIMESLOT_CTRL = 3'h4;
    localparam logic [2:0] REG_BUS_FORMAT = 3'h5;
    localparam logic [2:0] REG_MODE = 3'h6;
    localparam logic [2:0] REG_STATUS = 3'h7;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TEST_CLK_EN_BIT = 0;
    localparam int EXT_BAUD_EN_BIT = 0;
    localparam int EXT_SYNC_EN_BIT = 3;
    localparam int FIRST_FSC_ALIGN_BIT = 3;
    localparam int SECOND_ALIGN_EN_BIT = 1;
    localparam int SECOND_REF_OUT_BIT = 4;
    localparam int SECOND_ALIGN_OUT_BIT = 5;
    localparam int TIMESLOT_SPEED_BIT = 4;
    localparam int BUS_FORMAT_SPEED_BIT = 2;
    localparam int MODE_NT_BIT = 0;
    localparam int MODE_BUS_2BD_BIT = 1;
    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_HZ = 40000000;
    localparam longint BAUD_HZ = 80000;
    localparam logic [9:0] BAUD_CYCLES = 10'(CLK_HZ / BAUD_HZ);
    localparam logic [9:0] BAUD_HALF = 10'(CLK_HZ / BAUD_HZ / 2);
    localparam logic [10:0] SF_BAUDS = 11'd1440;
    localparam logic [10:0] FRAME_BAUDS = 11'd120;
    localparam logic [10:0] SYNC_LEAD = 11'd8;
    localparam logic [10:0] SYNC_BAUD = 11'(FRAME_BAUDS - SYNC_LEAD);
    localparam longint REF_HZ = 8000;
    localparam logic [12:0] REF_CYCLES = 13'(CLK_HZ / REF_HZ);
    localparam logic [12:0] REF_TOL = 13'd50;
    localparam int NCO_W = 24;
    localparam longint F512K = 512000;
    localparam longint F2048K = 2048000;
    localparam longint F2560K = 2560000;
    localparam logic [23:0] INC_512K = 24'((F512K << NCO_W) / CLK_HZ);
    localparam logic [23:0] INC_2048K = 24'((F2048K << NCO_W) / CLK_HZ);
    localparam logic [23:0] INC_2560K = 24'((F2560K << NCO_W) / CLK_HZ);
endpackage

// ==== rtl/ssc_sync_clock.sv ====
// superframe sync, alignment pin and reference clock outputs
`timescale 1ns/10ps
`default_nettype none
module ssc_sync_clock (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic host_mode_select_i,
    input wire logic clock_rate_select_i,
    input wire logic frame_sync_i,
    input wire logic tx_frame_alignment_pin_i,
    output logic tx_frame_alignment_pin_o,
    output logic tx_frame_alignment_pin_oe_o,
    input wire logic freq_reference_pin_i,
    output logic freq_reference_pin_o,
    output logic freq_reference_pin_oe_o,
    output logic tx_baud_clock_o,
    output logic tx_superframe_sync_out_o,
    output logic bus_data_clock_o,
    output logic locked_freq_out_o
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] test_ctrl_q, test_ctrl_d;
    logic [7:0] ext_ctrl_q, ext_ctrl_d;
    logic [7:0] first_init_q, first_init_d;
    logic [7:0] second_init_q, second_init_d;
    logic [7:0] timeslot_q, timeslot_d;
    logic [7:0] bus_format_q, bus_format_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] status;

    always_comb begin
        test_ctrl_d = test_ctrl_q;
        ext_ctrl_d = ext_ctrl_q;
        first_init_d = first_init_q;
        second_init_d = second_init_q;
        timeslot_d = timeslot_q;
        bus_format_d = bus_format_q;
        mode_d = mode_q;
        rdata_d = 8'h00;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ssc_pkg::REG_TEST_CTRL: test_ctrl_d = reg_wdata_i;
                ssc_pkg::REG_EXT_CTRL: ext_ctrl_d = reg_wdata_i;
                ssc_pkg::REG_FIRST_INIT: first_init_d = reg_wdata_i;
                ssc_pkg::REG_SECOND_INIT: second_init_d = reg_wdata_i;
                ssc_pkg::REG_TIMESLOT_CTRL: timeslot_d = reg_wdata_i;
                ssc_pkg::REG_BUS_FORMAT: bus_format_d = reg_wdata_i;
                ssc_pkg::REG_MODE: mode_d = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ssc_pkg::REG_TEST_CTRL: rdata_d = test_ctrl_q;
                ssc_pkg::REG_EXT_CTRL: rdata_d = ext_ctrl_q;
                ssc_pkg::REG_FIRST_INIT: rdata_d = first_init_q;
                ssc_pkg::REG_SECOND_INIT: rdata_d = second_init_q;
                ssc_pkg::REG_TIMESLOT_CTRL: rdata_d = timeslot_q;
                ssc_pkg::REG_BUS_FORMAT: rdata_d = bus_format_q;
                ssc_pkg::REG_MODE: rdata_d = mode_q;
                default: rdata_d = status;
            endcase
        end
    end

    // all registers clear at reset, so the alignment pin starts undriven
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            test_ctrl_q <= ssc_pkg::REG_RESET;
            ext_ctrl_q <= ssc_pkg::REG_RESET;
            first_init_q <= ssc_pkg::REG_RESET;
            second_init_q <= ssc_pkg::REG_RESET;
            timeslot_q <= ssc_pkg::REG_RESET;
            bus_format_q <= ssc_pkg::REG_RESET;
            mode_q <= ssc_pkg::REG_RESET;
            rdata_q <= 8'h00;
        end else begin
            test_ctrl_q <= test_ctrl_d;
            ext_ctrl_q <= ext_ctrl_d;
            first_init_q <= first_init_d;
            second_init_q <= second_init_d;
            timeslot_q <= timeslot_d;
            bus_format_q <= bus_format_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_o = rdata_q;

    // ************************************************************
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    // ************************************************************
    localparam int NS = 5;
    logic [NS-1:0] pins_raw;
    logic [NS-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    assign pins_raw = {frame_sync_i, tx_frame_alignment_pin_i,
                       freq_reference_pin_i, clock_rate_select_i,
                       host_mode_select_i};

    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < NS; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    logic host_mode, rate_sel, ref_in, align_in, fsync_in;
    assign host_mode = filt_q[0];
    assign rate_sel = filt_q[1];
    assign ref_in = filt_q[2];
    assign align_in = filt_q[3];
    assign fsync_in = filt_q[4];

    // ************************************************************
    // mode decode
    // ************************************************************
    logic nt_mode, clk_en, baud_out_en, sync_en, align_en;
    logic fsc_align, align_drive, ref_drive;
    assign nt_mode = mode_q[ssc_pkg::MODE_NT_BIT];
    assign clk_en = test_ctrl_q[ssc_pkg::TEST_CLK_EN_BIT];
    assign baud_out_en = clk_en | ext_ctrl_q[ssc_pkg::EXT_BAUD_EN_BIT];
    assign sync_en = clk_en & ext_ctrl_q[ssc_pkg::EXT_SYNC_EN_BIT];
    assign align_en = second_init_q[ssc_pkg::SECOND_ALIGN_EN_BIT];
    assign fsc_align = host_mode & mode_q[ssc_pkg::MODE_BUS_2BD_BIT]
                     & first_init_q[ssc_pkg::FIRST_FSC_ALIGN_BIT];
    // line-card input unless bit 5 turns it round; terminal drives whenever bit 1 enables alignment
    assign align_drive = align_en & (nt_mode
                       | second_init_q[ssc_pkg::SECOND_ALIGN_OUT_BIT]);
    assign ref_drive = nt_mode & host_mode
                     & second_init_q[ssc_pkg::SECOND_REF_OUT_BIT];

    // ************************************************************
    // baud timing and superframe position
    // ************************************************************
    logic [9:0] baud_div_q, baud_div_d;
    logic [10:0] baud_idx_q, baud_idx_d;
    logic src_q, src_d, align_edge, baud_tick;
    logic sfs_q, sfs_d, align_out_q, align_out_d;

    // frame sync modulation replaces the pin as alignment source
    assign src_d = fsc_align ? fsync_in : align_in;
    assign align_edge = align_en & ~align_drive & src_d & ~src_q;
    assign baud_tick = (baud_div_q == ssc_pkg::BAUD_CYCLES - 10'd1);

    always_comb begin
        baud_div_d = baud_tick ? 10'd0 : baud_div_q + 10'd1;
        baud_idx_d = baud_idx_q;
        sfs_d = sfs_q;
        align_out_d = align_out_q;
        if (baud_tick) begin
            if (baud_idx_q == ssc_pkg::SF_BAUDS - 11'd1) begin
                baud_idx_d = 11'd0;
            end else begin
                baud_idx_d = baud_idx_q + 11'd1;
            end
            // one baud wide, eight bauds ahead of the second sync word
            sfs_d = (baud_idx_d == ssc_pkg::SYNC_BAUD);
            align_out_d = (baud_idx_d == 11'd0);
        end
        if (align_edge) begin
            // external mark restarts the superframe at its first frame
            baud_div_d = 10'd0;
            baud_idx_d = 11'd0;
            sfs_d = 1'b0;
            align_out_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            baud_div_q <= 10'd0;
            baud_idx_q <= 11'd0;
            src_q <= 1'b0;
            sfs_q <= 1'b0;
            align_out_q <= 1'b0;
        end else begin
            baud_div_q <= baud_div_d;
            baud_idx_q <= baud_idx_d;
            src_q <= src_d;
            sfs_q <= sfs_d;
            align_out_q <= align_out_d;
        end
    end

    // ************************************************************
    // 8 kHz reference period monitor
    // ************************************************************
    // the loop itself is analog; here only the reference period is
    // checked so software can see whether the lock source is sane
    logic [12:0] ref_cnt_q, ref_cnt_d;
    logic ref_prev_q, ref_ok_q, ref_ok_d;

    always_comb begin
        ref_ok_d = ref_ok_q;
        ref_cnt_d = ref_cnt_q;
        if (ref_cnt_q != 13'h1FFF) begin
            ref_cnt_d = ref_cnt_q + 13'd1;
        end
        if (nt_mode || ref_drive) begin
            ref_ok_d = 1'b0;
            ref_cnt_d = 13'd0;
        end else if (ref_in && !ref_prev_q) begin
            ref_cnt_d = 13'd0;
            ref_ok_d = (ref_cnt_q + 13'd1 >= ssc_pkg::REF_CYCLES
                        - ssc_pkg::REF_TOL)
                     && (ref_cnt_q + 13'd1 <= ssc_pkg::REF_CYCLES
                        + ssc_pkg::REF_TOL);
        end else if (ref_cnt_q > ssc_pkg::REF_CYCLES + ssc_pkg::REF_TOL) begin
            ref_ok_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ref_cnt_q <= 13'd0;
            ref_prev_q <= 1'b0;
            ref_ok_q <= 1'b0;
        end else begin
            ref_cnt_q <= ref_cnt_d;
            ref_prev_q <= ref_in;
            ref_ok_q <= ref_ok_d;
        end
    end

    // ************************************************************
    // data clock synthesis
    // ************************************************************
    // phase accumulators: rates are not integer divisions of 40 MHz,
    // so edges carry one system clock of jitter
    logic [23:0] dcl_acc_q, dcl_acc_d, dcl_inc;
    logic [23:0] lck_acc_q, lck_acc_d, lck_inc;

    always_comb begin
        if (!bus_format_q[ssc_pkg::BUS_FORMAT_SPEED_BIT]) begin
            dcl_inc = ssc_pkg::INC_512K;
        end else if (timeslot_q[ssc_pkg::TIMESLOT_SPEED_BIT]) begin
            dcl_inc = ssc_pkg::INC_2560K;
        end else begin
            dcl_inc = ssc_pkg::INC_2048K;
        end
        lck_inc = rate_sel ? ssc_pkg::INC_2048K : ssc_pkg::INC_512K;
        dcl_acc_d = dcl_acc_q + dcl_inc;
        lck_acc_d = lck_acc_q + lck_inc;
        // realigning to superframe start keeps the clocks line-locked
        if (nt_mode && baud_tick && baud_idx_d == 11'd0) begin
            dcl_acc_d = 24'h000000;
            lck_acc_d = 24'h000000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dcl_acc_q <= 24'h000000;
            lck_acc_q <= 24'h000000;
        end else begin
            dcl_acc_q <= dcl_acc_d;
            lck_acc_q <= lck_acc_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic baud_clk;
    assign baud_clk = (baud_div_q < ssc_pkg::BAUD_HALF);
    assign tx_baud_clock_o = baud_out_en & baud_clk;
    assign tx_superframe_sync_out_o = sync_en & sfs_q;
    assign tx_frame_alignment_pin_oe_o = align_drive;
    assign tx_frame_alignment_pin_o = align_drive & align_out_q;
    assign freq_reference_pin_oe_o = ref_drive;
    assign freq_reference_pin_o = ref_drive & dcl_acc_q[23];
    assign bus_data_clock_o = nt_mode & dcl_acc_q[23];
    // bus-controlled mode only, and not while baud clock is out
    assign locked_freq_out_o = ~host_mode & ~baud_out_en
                             & lck_acc_q[23];

    assign status = {3'b000, baud_out_en, nt_mode, host_mode,
                     align_drive, ref_ok_q};
endmodule // ssc_sync_clock
`default_nettype wire

// ==== test/ssc_sync_clock_asserts.sv ====
// assertions on the superframe sync and clock pins
`timescale 1ns/10ps
`default_nettype none
module ssc_sync_clock_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic frame_sync_i,
    input wire logic tx_frame_alignment_pin_i,
    input wire logic tx_frame_alignment_pin_oe_o,
    input wire logic freq_reference_pin_o,
    input wire logic freq_reference_pin_oe_o,
    input wire logic tx_baud_clock_o,
    input wire logic tx_superframe_sync_out_o,
    input wire logic bus_data_clock_o,
    input wire logic locked_freq_out_o
);
    // *****
    // register shadow and run counters
    // *****
    logic [7:0] sh_q [8];
    logic [10:0] calm_q, sync_run_q, baud_run_q, baud_per_q;
    logic gate, baud_en, drive;
    assign gate = sh_q[0][0] & sh_q[1][3];
    assign baud_en = sh_q[0][0] | sh_q[1][0];
    assign drive = sh_q[3][1] & (sh_q[6][0] | sh_q[3][5]);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sh_q <= '{default: 8'h00};
            calm_q <= 11'h000;
        end else begin
            if (reg_wr_i)
                sh_q[reg_addr_i] <= reg_wdata_i;
            // restarts and enable changes cut runs short
            if ($rose(tx_frame_alignment_pin_i) || $rose(frame_sync_i)
                || !gate || $changed(baud_en))
                calm_q <= 11'h000;
            else if (calm_q != 11'h7FF)
                calm_q <= calm_q + 11'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        sync_run_q <= tx_superframe_sync_out_o ? sync_run_q + 11'h001
                                               : 11'h000;
        baud_run_q <= tx_baud_clock_o ? baud_run_q + 11'h001 : 11'h000;
        baud_per_q <= $rose(tx_baud_clock_o) ? 11'h001
                                             : baud_per_q + 11'h001;
    end
    // *****
    // properties
    // *****
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sync_start;
        $rose(tx_superframe_sync_out_o) && $past(gate);
    endsequence
    sequence s_sync_end;
        $fell(tx_superframe_sync_out_o) && gate && calm_q > 11'h1FE;
    endsequence
    a_sync_gated: assert property (tx_superframe_sync_out_o |-> gate)
        else $error("sync pulse without both enables");
    a_sync_on_baud: assert property (s_sync_start
        |-> $rose(tx_baud_clock_o))
        else $error("sync pulse not aligned to baud clock");
    a_sync_width: assert property (s_sync_end
        |-> sync_run_q == 11'h1F4)
        else $error("sync pulse not one baud long");
    a_baud_high: assert property ($fell(tx_baud_clock_o)
        && calm_q > 11'h104 |-> baud_run_q == 11'h0FA)
        else $error("baud clock high time wrong");
    a_baud_period: assert property ($rose(tx_baud_clock_o)
        && calm_q > 11'h1FE |-> baud_per_q == 11'h1F4)
        else $error("baud clock period wrong");
    a_pin_dir: assert property (
        tx_frame_alignment_pin_oe_o == drive)
        else $error("alignment pin direction wrong");
    a_ref_dir: assert property (freq_reference_pin_oe_o
        |-> sh_q[6][0] && sh_q[3][4]) else $error("reference pin driven");
    a_ref_clock: assert property (freq_reference_pin_oe_o
        |-> freq_reference_pin_o == bus_data_clock_o)
        else $error("reference pin not carrying data clock");
    a_locked_off: assert property (locked_freq_out_o |-> !baud_en)
        else $error("locked output active with baud clock on");
endmodule // ssc_sync_clock_asserts
`default_nettype wire

// ==== test/ssc_far_end.sv ====
// framing logic and switch reference beside the block
`timescale 1ns/10ps
`default_nettype none
module ssc_far_end (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic align_go_i,
    output logic align_o,
    output logic ref_o
);
    logic [12:0] ref_cnt_q;
    logic [9:0] align_cnt_q;
    assign ref_o = ref_cnt_q < 13'h09C4;
    // idle low: the far end drives the pin low between pulses
    assign align_o = align_cnt_q != 10'h000;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ref_cnt_q <= 13'h0000;
            align_cnt_q <= 10'h000;
        end else begin
            ref_cnt_q <= (ref_cnt_q == 13'h1387) ? 13'h0000
                                                 : ref_cnt_q + 13'h0001;
            if (align_go_i)
                align_cnt_q <= 10'h1F4;
            else if (align_cnt_q != 10'h000)
                align_cnt_q <= align_cnt_q - 10'h001;
        end
    end
endmodule // ssc_far_end
`default_nettype wire

// ==== test/tb_superframe_sync_clock_outputs.sv ====
// testbench for the superframe sync and clock output block
`timescale 1ns/10ps
`default_nettype none
module tb_superframe_sync_clock_outputs;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic host_mode = 1'b0;
    logic rate_sel = 1'b0;
    logic fsync = 1'b0;
    logic align_go = 1'b0;
    logic [7:0] rdata;
    logic sfa_o, sfa_oe, sfa_far, sfa_pin, ref_o, ref_oe, ref_far, ref_pin;
    logic baud, sync, dclk, locked;
    int fail_count = 0;
    int checks_done = 0;
    assign sfa_pin = sfa_oe ? sfa_o : sfa_far;
    assign ref_pin = ref_oe ? ref_o : ref_far;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    ssc_sync_clock i_ssc_sync_clock (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
        .host_mode_select_i(host_mode), .clock_rate_select_i(rate_sel),
        .frame_sync_i(fsync), .tx_frame_alignment_pin_i(sfa_pin),
        .tx_frame_alignment_pin_o(sfa_o),
        .tx_frame_alignment_pin_oe_o(sfa_oe),
        .freq_reference_pin_i(ref_pin), .freq_reference_pin_o(ref_o),
        .freq_reference_pin_oe_o(ref_oe), .tx_baud_clock_o(baud),
        .tx_superframe_sync_out_o(sync), .bus_data_clock_o(dclk),
        .locked_freq_out_o(locked));
    ssc_far_end i_ssc_far_end (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .align_go_i(align_go), .align_o(sfa_far), .ref_o(ref_far));
    // *****
    // shared tasks
    // *****
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] got);
        checks_done++;
        if (got !== e) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", what, e, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e, string nm);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1 chk(nm, {24'h0, e}, {24'h0, rdata});
    endtask
    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
    endtask
    // n counts cycles to a rising edge of sync (pick) or baud
    task automatic wait_rise(input bit pick, input int lim, output int n);
        logic prev;
        prev = pick ? sync : baud;
        for (n = 1; n <= lim; n++) begin
            @(posedge clk_sys_i);
            #1;
            if (!prev && (pick ? sync : baud))
                return;
            prev = pick ? sync : baud;
        end
        n = -1;
    endtask
    task automatic count(input bit pick, input int e);
        logic prev;
        int n;
        prev = 1'b0;
        n = 0;
        repeat (5000) begin
            @(posedge clk_sys_i);
            #1;
            if (!prev && (pick ? locked : dclk))
                n++;
            prev = pick ? locked : dclk;
        end
        chk("clock edges", e, (n >= e - 1 && n <= e + 1) ? e : n);
    endtask
    // *****
    // scenarios
    // *****
    task automatic t_reset_state();
        do_reset();
        #1 chk("align oe", 0, {31'h0, sfa_oe});
        rd(3'h3, 8'h00, "second init");
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, "status");
    endtask
    task automatic t_lt_align();
        int n;
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h08);
        wr(3'h3, 8'h02);
        #1 chk("align oe lt", 0, {31'h0, sfa_oe});
        @(negedge baud);
        @(posedge clk_sys_i);
        align_go <= 1'b1;
        @(posedge clk_sys_i);
        align_go <= 1'b0;
        wait_rise(1'b0, 20, n);
        chk("baud restart", 1, {31'h0, n > 0});
        wait_rise(1'b1, 60000, n);
        chk("sync lead", 56000, n);
        for (n = 0; sync === 1'b1 && n < 600; n++)
            @(posedge clk_sys_i) #1;
        chk("sync width", 500, n);
        rd(3'h7, 8'h11, "status lt");
    endtask
    task automatic t_pin_dir();
        logic [7:0] md [4] = '{8'h00, 8'h00, 8'h01, 8'h00};
        logic [7:0] si [4] = '{8'h20, 8'h22, 8'h02, 8'h02};
        logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        do_reset();
        for (int i = 0; i < 4; i++) begin
            wr(3'h6, md[i]);
            wr(3'h3, si[i]);
            #1 chk("align oe", {31'h0, ex[i]}, {31'h0, sfa_oe});
            chk("align out", 0, {31'h0, sfa_o});
        end
    endtask
    task automatic t_fsc_align();
        int n;
        do_reset();
        host_mode <= 1'b1;
        wr(3'h6, 8'h02);
        wr(3'h2, 8'h08);
        wr(3'h3, 8'h02);
        wr(3'h0, 8'h01);
        @(negedge baud);
        repeat (20) @(posedge clk_sys_i);
        fsync <= 1'b1;
        // baud is low here, so only a restart can raise it this soon
        wait_rise(1'b0, 20, n);
        @(posedge clk_sys_i);
        fsync <= 1'b0;
        chk("frame sync restart", 1, {31'h0, n > 0});
    endtask
    task automatic t_ref_out();
        logic [7:0] bf [3] = '{8'h00, 8'h04, 8'h04};
        logic [7:0] ts [3] = '{8'h00, 8'h00, 8'h10};
        int ed [3] = '{64, 256, 320};
        do_reset();
        host_mode <= 1'b1;
        wr(3'h6, 8'h01);
        wr(3'h3, 8'h10);
        repeat (8) @(posedge clk_sys_i);
        #1 chk("ref oe", 1, {31'h0, ref_oe});
        for (int i = 0; i < 3; i++) begin
            wr(3'h5, bf[i]);
            wr(3'h4, ts[i]);
            count(1'b0, ed[i]);
        end
    endtask
    task automatic t_locked();
        do_reset();
        host_mode <= 1'b0;
        rate_sel <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        count(1'b1, 256);
        @(posedge clk_sys_i);
        rate_sel <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        count(1'b1, 64);
        wr(3'h1, 8'h01);
        count(1'b1, 0);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        t_reset_state();
        t_lt_align();
        t_pin_dir();
        t_fsc_align();
        t_ref_out();
        t_locked();
        print_verdict();
    end
    // about 90k cycles of work, so 100k is a hang
    initial begin
        #(25 * 100000);
        fail_count++;
        print_verdict();
    end
endmodule // tb_superframe_sync_clock_outputs
bind ssc_sync_clock ssc_sync_clock_asserts i_ssc_sync_clock_asserts (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .frame_sync_i, .tx_frame_alignment_pin_i, .tx_frame_alignment_pin_oe_o,
    .freq_reference_pin_o, .freq_reference_pin_oe_o, .tx_baud_clock_o,
    .tx_superframe_sync_out_o, .bus_data_clock_o, .locked_freq_out_o);
`default_nettype wire
